// ==== rtl/fcss_defs.vh ====
// Command codes, status bit positions and bus timing counts for the flash host controller.
`ifndef FCSS_DEFS_VH
`define FCSS_DEFS_VH

`define FCSS_CMD_READ_STATUS   8'h70
`define FCSS_CMD_CLEAR_STATUS  8'h50
`define FCSS_CMD_READ_ARRAY    8'hFF
`define FCSS_CMD_ERASE_SETUP   8'h20
`define FCSS_CMD_CHIP_SETUP    8'h30
`define FCSS_CMD_CONFIRM       8'hD0
`define FCSS_CMD_PROG_SETUP    8'h40
`define FCSS_CMD_PROG_ALT      8'h10
`define FCSS_CMD_SUSPEND       8'hB0
`define FCSS_CMD_LOCK_SETUP    8'h60
`define FCSS_CMD_LOCK_BLOCK    8'h01
`define FCSS_CMD_LOCK_PERM     8'hF1

`define FCSS_SB_READY          7
`define FCSS_SB_ERASE_SUSP     6
`define FCSS_SB_ERASE_ERR      5
`define FCSS_SB_PROG_ERR       4
`define FCSS_SB_SUPPLY_ERR     3
`define FCSS_SB_PROG_SUSP      2
`define FCSS_SB_PROTECT        1
`define FCSS_SB_MASK           8'hFE

`define FCSS_OP_READ_ARRAY     3'h0
`define FCSS_OP_BLOCK_ERASE    3'h1
`define FCSS_OP_CHIP_ERASE     3'h2
`define FCSS_OP_PROGRAM        3'h3
`define FCSS_OP_SUSPEND        3'h4
`define FCSS_OP_RESUME         3'h5
`define FCSS_OP_LOCK_BLOCK     3'h6
`define FCSS_OP_LOCK_PERM      3'h7

`define FCSS_PULSE_NS          80
`define FCSS_CLK_NS            8
`define FCSS_PULSE_CYC         ((`FCSS_PULSE_NS + `FCSS_CLK_NS - 1) / `FCSS_CLK_NS)

`endif

// ==== rtl/fcss_bus_cycle.v ====
// One write or read cycle on the flash parallel port, strobe width set by a counter.
`timescale 1ns/1ps
`include "fcss_defs.vh"
module fcss_bus_cycle
#(
   parameter AW    = 21,
   parameter DW    = 16,
   parameter PULSE = `FCSS_PULSE_CYC
)
(
   input  wire          clk,
   input  wire          rst_n,
   input  wire          start,
   input  wire          is_write,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] wdata,
   output reg           busy,
   output reg           done,
   output reg  [DW-1:0] rdata,
   output reg  [AW-1:0] flash_addr,
   output reg  [DW-1:0] flash_dq_out,
   output reg           flash_dq_oe_n,
   input  wire [DW-1:0] flash_dq_in,
   output reg           flash_ce_n,
   output reg           flash_we_n,
   output reg           flash_oe_n
);

   reg [7:0] count;
   reg       write_cyc;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy          <= 1'b0;
         done          <= 1'b0;
         rdata         <= {DW{1'b0}};
         flash_addr    <= {AW{1'b0}};
         flash_dq_out  <= {DW{1'b0}};
         flash_dq_oe_n <= 1'b1;
         flash_ce_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         count         <= 8'h00;
         write_cyc     <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (!busy && start)
         begin
            busy          <= 1'b1;
            write_cyc     <= is_write;
            flash_addr    <= addr;
            flash_dq_out  <= wdata;
            flash_dq_oe_n <= !is_write;
            flash_ce_n    <= 1'b0;
            flash_we_n    <= !is_write;
            flash_oe_n    <= is_write;
            count         <= PULSE[7:0];
         end
         else if (busy)
         begin
            if (count != 8'h00)
               count <= count - 8'h01;
            else
            begin
               // Data is captured before the strobes rise so the device still drives it.
               if (!write_cyc)
                  rdata <= flash_dq_in;
               busy          <= 1'b0;
               done          <= 1'b1;
               flash_ce_n    <= 1'b1;
               flash_we_n    <= 1'b1;
               flash_oe_n    <= 1'b1;
               flash_dq_oe_n <= 1'b1;
            end
         end
      end
   end

endmodule

// ==== rtl/fcss_host.v ====
// Host sequencer that issues flash command sequences and polls and decodes the status byte.
//
// Overview of operation
// - Write status-read command, poll status bit 7 until ready.
// - Chip erase is setup then confirm write; bit 1 if all locked.
// - On any error bit, issue clear-status before any retry.
// - Program is setup write of either code then data write.
// - Programs may follow back to back checking only ready.
// - Issue read-array after the last operation of a sequence; the host writes it itself only after clear-status or a program suspend.
// - While suspended read other locations; resume restarts program.
// - Lock set is setup then confirm code selecting block or permanent.
// - Block erase is setup code then confirm inside the block.
// - Status bit 0 is reserved and masked out.
`timescale 1ns/1ps
`include "fcss_defs.vh"
module fcss_host
#(
   parameter AW    = 21,
   parameter DW    = 16,
   parameter PULSE = `FCSS_PULSE_CYC
)
(
   input  wire          clk,
   input  wire          rst_n,
   input  wire          op_valid,
   input  wire [2:0]    op_code,
   input  wire          op_alt_setup,
   input  wire [AW-1:0] op_addr,
   input  wire [DW-1:0] op_data,
   output reg           op_ready,
   output reg           op_done,
   output reg  [7:0]    status_byte,
   output reg           err_seq,
   output reg           err_erase,
   output reg           err_prog,
   output reg           err_supply,
   output reg           err_protect,
   output reg           prog_suspended,
   output reg           erase_suspended_flag,
   input  wire          rd_valid,
   input  wire [AW-1:0] rd_addr,
   output reg           rd_done,
   output reg  [DW-1:0] rd_data,
   output reg  [AW-1:0] flash_addr,
   output reg  [DW-1:0] flash_dq_out,
   output reg           flash_dq_oe_n,
   input  wire [DW-1:0] flash_dq_in,
   output reg           flash_ce_n,
   output reg           flash_we_n,
   output reg           flash_oe_n
);

   // ------------------------------------------------------------------
   // States
   // ------------------------------------------------------------------
   localparam S_IDLE  = 3'd0;
   localparam S_CMD1  = 3'd1;
   localparam S_CMD2  = 3'd2;
   localparam S_STAT  = 3'd3;
   localparam S_POLL  = 3'd4;
   localparam S_CLEAR = 3'd5;
   localparam S_ARRAY = 3'd6;
   localparam S_READ  = 3'd7;

   reg  [2:0]    state;
   reg  [2:0]    op;
   reg           alt;
   reg  [AW-1:0] addr_q;
   reg  [DW-1:0] data_q;
   reg           cyc_start;
   reg           cyc_write;
   reg  [AW-1:0] cyc_addr;
   reg  [DW-1:0] cyc_wdata;
   reg           launched;
   wire          cyc_busy;
   wire          cyc_done;
   wire [DW-1:0] cyc_rdata;
   wire [AW-1:0] p_addr;
   wire [DW-1:0] p_dq;
   wire          p_oe_n;
   wire          p_ce_n;
   wire          p_we_n;
   wire          p_rd_n;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function [DW-1:0] cmd;
      input [7:0] code;
      begin
         cmd = {{(DW-8){1'b0}}, code};
      end
   endfunction

   // Second write of each sequence; a lone command has none.
   function [DW-1:0] second_word;
      input [2:0]    o;
      input [DW-1:0] d;
      begin
         case (o)
            `FCSS_OP_PROGRAM:    second_word = d;
            `FCSS_OP_LOCK_BLOCK: second_word = cmd(`FCSS_CMD_LOCK_BLOCK);
            `FCSS_OP_LOCK_PERM:  second_word = cmd(`FCSS_CMD_LOCK_PERM);
            default:             second_word = cmd(`FCSS_CMD_CONFIRM);
         endcase
      end
   endfunction

   fcss_bus_cycle
   #(
      .AW    (AW),
      .DW    (DW),
      .PULSE (PULSE)
   )
   u_cycle
   (
      .clk           (clk),
      .rst_n         (rst_n),
      .start         (cyc_start),
      .is_write      (cyc_write),
      .addr          (cyc_addr),
      .wdata         (cyc_wdata),
      .busy          (cyc_busy),
      .done          (cyc_done),
      .rdata         (cyc_rdata),
      .flash_addr    (p_addr),
      .flash_dq_out  (p_dq),
      .flash_dq_oe_n (p_oe_n),
      .flash_dq_in   (flash_dq_in),
      .flash_ce_n    (p_ce_n),
      .flash_we_n    (p_we_n),
      .flash_oe_n    (p_rd_n)
   );

   // Pins are re-registered so every top output comes from a flip-flop.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flash_addr    <= {AW{1'b0}};
         flash_dq_out  <= {DW{1'b0}};
         flash_dq_oe_n <= 1'b1;
         flash_ce_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
      end
      else
      begin
         flash_addr    <= p_addr;
         flash_dq_out  <= p_dq;
         flash_dq_oe_n <= p_oe_n;
         flash_ce_n    <= p_ce_n;
         flash_we_n    <= p_we_n;
         flash_oe_n    <= p_rd_n;
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state                <= S_IDLE;
         op                   <= `FCSS_OP_READ_ARRAY;
         alt                  <= 1'b0;
         addr_q               <= {AW{1'b0}};
         data_q               <= {DW{1'b0}};
         cyc_start            <= 1'b0;
         cyc_write            <= 1'b0;
         cyc_addr             <= {AW{1'b0}};
         cyc_wdata            <= {DW{1'b0}};
         launched             <= 1'b0;
         op_ready             <= 1'b0;
         op_done              <= 1'b0;
         status_byte          <= 8'h00;
         err_seq              <= 1'b0;
         err_erase            <= 1'b0;
         err_prog             <= 1'b0;
         err_supply           <= 1'b0;
         err_protect          <= 1'b0;
         prog_suspended       <= 1'b0;
         erase_suspended_flag <= 1'b0;
         rd_done              <= 1'b0;
         rd_data              <= {DW{1'b0}};
      end
      else
      begin
         cyc_start <= 1'b0;
         op_done   <= 1'b0;
         rd_done   <= 1'b0;
         case (state)
            S_IDLE:
            begin
               op_ready <= 1'b1;
               launched <= 1'b0;
               if (op_valid)
               begin
                  op_ready <= 1'b0;
                  op       <= op_code;
                  alt      <= op_alt_setup;
                  addr_q   <= op_addr;
                  data_q   <= op_data;
                  state    <= S_CMD1;
               end
               else if (rd_valid)
               begin
                  op_ready <= 1'b0;
                  addr_q   <= rd_addr;
                  state    <= S_READ;
               end
            end
            S_CMD1:
            begin
               if (!launched && !cyc_busy)
               begin
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b1;
                  cyc_addr  <= {AW{1'b0}};
                  launched  <= 1'b1;
                  case (op)
                     `FCSS_OP_BLOCK_ERASE: cyc_wdata <= cmd(`FCSS_CMD_ERASE_SETUP);
                     `FCSS_OP_CHIP_ERASE:  cyc_wdata <= cmd(`FCSS_CMD_CHIP_SETUP);
                     `FCSS_OP_PROGRAM:     cyc_wdata <= alt ? cmd(`FCSS_CMD_PROG_ALT)
                                                            : cmd(`FCSS_CMD_PROG_SETUP);
                     `FCSS_OP_SUSPEND:     cyc_wdata <= cmd(`FCSS_CMD_SUSPEND);
                     `FCSS_OP_RESUME:      cyc_wdata <= cmd(`FCSS_CMD_CONFIRM);
                     `FCSS_OP_READ_ARRAY:  cyc_wdata <= cmd(`FCSS_CMD_READ_ARRAY);
                     default:              cyc_wdata <= cmd(`FCSS_CMD_LOCK_SETUP);
                  endcase
               end
               else if (cyc_done)
               begin
                  launched <= 1'b0;
                  if (op == `FCSS_OP_READ_ARRAY)
                  begin
                     prog_suspended <= 1'b0;
                     state          <= S_IDLE;
                     op_done        <= 1'b1;
                  end
                  else if (op == `FCSS_OP_SUSPEND || op == `FCSS_OP_RESUME)
                     state <= S_STAT;
                  else
                     state <= S_CMD2;
               end
            end
            S_CMD2:
            begin
               if (!launched && !cyc_busy)
               begin
                  // Target address matters for program, block erase and block lock.
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b1;
                  cyc_addr  <= addr_q;
                  cyc_wdata <= second_word(op, data_q);
                  launched  <= 1'b1;
               end
               else if (cyc_done)
               begin
                  launched <= 1'b0;
                  state    <= S_STAT;
               end
            end
            S_STAT:
            begin
               if (!launched && !cyc_busy)
               begin
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b1;
                  cyc_addr  <= {AW{1'b0}};
                  cyc_wdata <= cmd(`FCSS_CMD_READ_STATUS);
                  launched  <= 1'b1;
               end
               else if (cyc_done)
               begin
                  launched <= 1'b0;
                  state    <= S_POLL;
               end
            end
            S_POLL:
            begin
               if (!launched && !cyc_busy)
               begin
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b0;
                  cyc_addr  <= {AW{1'b0}};
                  launched  <= 1'b1;
               end
               else if (cyc_done)
               begin
                  launched <= 1'b0;
                  // Error bits are only trusted once the ready bit is seen.
                  if (cyc_rdata[`FCSS_SB_READY])
                  begin
                     status_byte          <= cyc_rdata[7:0] & `FCSS_SB_MASK;
                     err_seq              <= cyc_rdata[`FCSS_SB_ERASE_ERR]
                                             & cyc_rdata[`FCSS_SB_PROG_ERR];
                     err_erase            <= cyc_rdata[`FCSS_SB_ERASE_ERR]
                                             & !cyc_rdata[`FCSS_SB_PROG_ERR];
                     err_prog             <= cyc_rdata[`FCSS_SB_PROG_ERR]
                                             & !cyc_rdata[`FCSS_SB_ERASE_ERR];
                     err_supply           <= cyc_rdata[`FCSS_SB_SUPPLY_ERR];
                     err_protect          <= cyc_rdata[`FCSS_SB_PROTECT];
                     erase_suspended_flag <= cyc_rdata[`FCSS_SB_ERASE_SUSP];
                     if (op == `FCSS_OP_SUSPEND)
                        prog_suspended <= cyc_rdata[`FCSS_SB_PROG_SUSP];
                     else if (op == `FCSS_OP_RESUME)
                        prog_suspended <= 1'b0;
                     // Sticky errors must be cleared before anything else is tried.
                     if ((cyc_rdata[7:0] & 8'h3A) != 8'h00)
                        state <= S_CLEAR;
                     else if (op == `FCSS_OP_SUSPEND && cyc_rdata[`FCSS_SB_PROG_SUSP])
                        state <= S_ARRAY;
                     else
                     begin
                        state   <= S_IDLE;
                        op_done <= 1'b1;
                     end
                  end
               end
            end
            S_CLEAR:
            begin
               if (!launched && !cyc_busy)
               begin
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b1;
                  cyc_addr  <= {AW{1'b0}};
                  cyc_wdata <= cmd(`FCSS_CMD_CLEAR_STATUS);
                  launched  <= 1'b1;
               end
               else if (cyc_done)
               begin
                  launched <= 1'b0;
                  state    <= S_ARRAY;
               end
            end
            S_ARRAY:
            begin
               if (!launched && !cyc_busy)
               begin
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b1;
                  cyc_addr  <= {AW{1'b0}};
                  cyc_wdata <= cmd(`FCSS_CMD_READ_ARRAY);
                  launched  <= 1'b1;
               end
               else if (cyc_done)
               begin
                  launched <= 1'b0;
                  state    <= S_IDLE;
                  op_done  <= 1'b1;
               end
            end
            S_READ:
            begin
               if (!launched && !cyc_busy)
               begin
                  cyc_start <= 1'b1;
                  cyc_write <= 1'b0;
                  cyc_addr  <= addr_q;
                  launched  <= 1'b1;
               end
               else if (cyc_done)
               begin
                  launched <= 1'b0;
                  rd_data  <= cyc_rdata;
                  rd_done  <= 1'b1;
                  state    <= S_IDLE;
               end
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

endmodule

// ==== test/fcss_flash_model.sv ====
// Behavioural flash device that answers the host controller's bus cycles.
`timescale 1ns/1ps
module fcss_flash_model
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire [20:0] flash_addr,
   input  wire [15:0] flash_dq_out,
   input  wire        flash_dq_oe_n,
   input  wire        flash_ce_n,
   input  wire        flash_we_n,
   input  wire        flash_oe_n,
   input  wire [7:0]  busy_len,
   input  wire [7:0]  inject,
   output wire [15:0] flash_dq_in
);
   reg         status_mode, susp, was_we;
   reg  [7:0]  setup, errs, busy_cnt, seen;
   reg  [20:0] abuf, prog_addr;
   reg  [15:0] wbuf, prog_data, last_dq;
   wire [7:0]  cmd  = wbuf[7:0];
   wire        busy = (busy_cnt != 8'h00) && !susp;
   wire [7:0]  sb   = {!busy, 1'b0, errs[5:3], susp, errs[1], 1'b0};
   wire        drv  = !flash_ce_n && !flash_oe_n;
   wire [15:0] arr  = (flash_addr == prog_addr) ? prog_data : flash_addr[15:0] ^ 16'h5A5A;
   // A released bus shows the inverse of the last value, so a late sample cannot pass.
   assign flash_dq_in = drv ? (status_mode ? {8'h00, sb} : arr) : ~last_dq;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_mode <= 1'b0;
         susp        <= 1'b0;
         was_we      <= 1'b0;
         setup       <= 8'h00;
         errs        <= 8'h00;
         busy_cnt    <= 8'h00;
         seen        <= 8'h00;
         prog_addr   <= 21'h00_0000;
         prog_data   <= 16'h0000;
         last_dq     <= 16'h0000;
      end
      else
      begin
         was_we <= !flash_we_n && !flash_ce_n;
         if (!flash_we_n && !flash_dq_oe_n)
         begin
            wbuf <= flash_dq_out;
            abuf <= flash_addr;
         end
         if (drv)
            last_dq <= flash_dq_in;
         if (busy)
         begin
            busy_cnt <= busy_cnt - 8'h01;
            if (busy_cnt == 8'h01)
               errs <= errs | (inject & 8'h3A);
         end
         if (was_we && flash_we_n)
         begin
            setup <= 8'h00;
            if (setup == 8'h40 || setup == 8'h10)
            begin
               seen      <= setup;
               prog_addr <= abuf;
               prog_data <= wbuf;
               busy_cnt  <= busy_len;
            end
            else if (setup != 8'h00)
            begin
               seen <= cmd;
               if ((setup == 8'h60) ? (cmd == 8'h01 || cmd == 8'hF1) : (cmd == 8'hD0))
                  busy_cnt <= busy_len;
               else
                  errs <= errs | 8'h30;
            end
            else
               case (cmd)
                  8'h70: status_mode <= 1'b1;
                  8'hFF: status_mode <= 1'b0;
                  8'h50: errs <= 8'h00;
                  8'hB0: susp <= busy;
                  8'hD0: susp <= 1'b0;
                  8'h20, 8'h30, 8'h40, 8'h10, 8'h60:
                  begin
                     setup       <= cmd;
                     status_mode <= 1'b1;
                  end
                  default: errs <= errs | 8'h30;
               endcase
         end
      end
   end
endmodule

// ==== test/fcss_host_assertions.sv ====
// Concurrent checks on the ports of the flash host controller.
`timescale 1ns/1ps
module fcss_host_assertions
#(
   parameter PULSE = 10
)
(
   input wire       clk,
   input wire       rst_n,
   input wire       op_valid,
   input wire       op_ready,
   input wire       op_done,
   input wire [7:0] status_byte,
   input wire       err_seq,
   input wire       err_erase,
   input wire       err_prog,
   input wire       err_supply,
   input wire       err_protect,
   input wire       flash_dq_oe_n,
   input wire       flash_we_n,
   input wire       flash_oe_n
);
   reg [7:0] low_cnt;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         low_cnt <= 8'h00;
      else
         low_cnt <= flash_we_n ? 8'h00 : low_cnt + 8'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_we_width;
      $rose(flash_we_n) |-> low_cnt == PULSE + 1;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
   property p_no_fight;
      !flash_oe_n |-> flash_dq_oe_n && flash_we_n;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("drive during read");
   property p_take;
      op_valid && op_ready |=> !op_ready ##1 !op_done;
   endproperty
   a_take: assert property (p_take) else $error("request not taken");
   property p_ready;
      op_done |-> status_byte[7] && !status_byte[0];
   endproperty
   a_ready: assert property (p_ready) else $error("done before ready");
   property p_seq;
      op_done |-> err_seq == (status_byte[5] && status_byte[4]);
   endproperty
   a_seq: assert property (p_seq) else $error("sequence error flag wrong");
   property p_erase;
      op_done |-> err_erase == (status_byte[5] && !status_byte[4]);
   endproperty
   a_erase: assert property (p_erase) else $error("erase error flag wrong");
   property p_prog;
      op_done |-> err_prog == (status_byte[4] && !status_byte[5]);
   endproperty
   a_prog: assert property (p_prog) else $error("program error flag wrong");
   property p_supply;
      op_done |-> err_supply == status_byte[3] && err_protect == status_byte[1];
   endproperty
   a_supply: assert property (p_supply) else $error("supply or protect flag wrong");
endmodule
bind fcss_host fcss_host_assertions #(.PULSE(PULSE)) u_chk
(
   .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready), .op_done(op_done),
   .status_byte(status_byte), .err_seq(err_seq), .err_erase(err_erase), .err_prog(err_prog),
   .err_supply(err_supply), .err_protect(err_protect), .flash_dq_oe_n(flash_dq_oe_n),
   .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
);

// ==== test/fcss_host_tb.sv ====
// Self-checking bench for the flash host controller against a device model.
`timescale 1ns/1ps
module fcss_host_tb;
   reg         clk, rst_n, op_valid, op_alt_setup, rd_valid;
   reg  [2:0]  op_code;
   reg  [20:0] op_addr, rd_addr, last_a;
   reg  [15:0] op_data, last_d, exp_sn;
   reg  [7:0]  busy_len, inject, exp_sb;
   wire        op_ready, op_done, err_seq, err_erase, err_prog, err_supply, err_protect;
   wire        prog_suspended, erase_suspended_flag, rd_done, flash_dq_oe_n, flash_ce_n;
   wire        flash_we_n, flash_oe_n;
   wire [7:0]  status_byte;
   wire [15:0] rd_data, flash_dq_out, flash_dq_in;
   wire [20:0] flash_addr;
   wire [17:0] optab  = {3'd7, 3'd6, 3'd3, 3'd3, 3'd2, 3'd1};
   wire [47:0] injtab = 48'h0208_3010_2000;
   integer     num_errors, num_checks, seed, i, k;
   fcss_host #(.PULSE(2)) uut
   (
      .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
      .op_alt_setup(op_alt_setup), .op_addr(op_addr), .op_data(op_data),
      .op_ready(op_ready), .op_done(op_done), .status_byte(status_byte), .err_seq(err_seq),
      .err_erase(err_erase), .err_prog(err_prog), .err_supply(err_supply),
      .err_protect(err_protect), .prog_suspended(prog_suspended),
      .erase_suspended_flag(erase_suspended_flag), .rd_valid(rd_valid), .rd_addr(rd_addr),
      .rd_done(rd_done), .rd_data(rd_data), .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in),
      .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n)
   );
   fcss_flash_model dev
   (
      .clk(clk), .rst_n(rst_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
      .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n), .busy_len(busy_len), .inject(inject),
      .flash_dq_in(flash_dq_in)
   );
   always #4 clk = ~clk;
   function [4:0] exp_err(input [7:0] s);
      exp_err = {s[5] & s[4], s[5] & ~s[4], s[4] & ~s[5], s[3], s[1]};
   endfunction
   function [15:0] exp_arr(input [20:0] a);
      exp_arr = (a == last_a) ? last_d : a[15:0] ^ 16'h5A5A;
   endfunction
   function [15:0] exp_seen(input [2:0] c, input alt);
      exp_seen = (c == 3'd3) ? (alt ? 16'h0010 : 16'h0040) :
                 (c == 3'd6) ? 16'h0001 : (c == 3'd7) ? 16'h00F1 : 16'h00D0;
   endfunction
   task check(input [15:0] seen, input [15:0] exp);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task summarize;
   begin
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   task await(input integer w);
      integer n;
   begin
      n = 0;
      @(posedge clk);
      while ((w == 0 ? op_ready : w == 1 ? op_done : rd_done) !== 1'b1)
      begin
         n = n + 1;
         if (n == 3000)
         begin
            num_errors = num_errors + 1;
            summarize;
         end
         @(posedge clk);
      end
   end
   endtask
   task do_op(input [2:0] c, input [7:0] inj);
   begin
      await(0);
      inject <= inj;
      busy_len <= 8'(1 + {$random(seed)} % 40);
      op_code <= c;
      op_alt_setup <= 1'($random(seed));
      op_addr <= 21'($random(seed));
      op_data <= 16'($random(seed));
      op_valid <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
      await(1);
      // A read-array op runs no poll, so the last status stands; lone commands leave seen.
      if (c != 3'd0)
         exp_sb = 8'h80 | (inj & 8'h3A);
      if ((c != 3'd0 && c < 3'd4) || c > 3'd5)
         exp_sn = exp_seen(c, op_alt_setup);
      check({8'h00, status_byte}, {8'h00, exp_sb});
      check({9'h000, prog_suspended, erase_suspended_flag, err_seq, err_erase,
             err_prog, err_supply, err_protect},
            {9'h000, exp_sb[2], exp_sb[6], exp_err(exp_sb)});
      check({8'h00, dev.seen}, exp_sn);
   end
   endtask
   task do_rd(input [20:0] a);
   begin
      await(0);
      rd_addr <= a;
      rd_valid <= 1'b1;
      @(posedge clk);
      rd_valid <= 1'b0;
      await(2);
      check(rd_data, exp_arr(a));
   end
   endtask
   initial
   begin
      seed = 32'hA087_2019;
      num_errors = 0;
      num_checks = 0;
      clk = 1'b0;
      rst_n = 1'b0;
      op_valid = 1'b0;
      op_code = 3'h0;
      op_alt_setup = 1'b0;
      op_addr = 21'h00_0000;
      op_data = 16'h0000;
      rd_valid = 1'b0;
      rd_addr = 21'h00_0000;
      busy_len = 8'h01;
      inject = 8'h00;
      last_a = 21'h00_0000;
      last_d = 16'h0000;
      exp_sb = 8'h00;
      exp_sn = 16'h0000;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // Scripted faults, then random ops clean to prove the clear, then random ones with faults.
      for (i = 0; i < 18; i = i + 1)
      begin
         k = (i < 6) ? i : {$random(seed)} % 6;
         do_op(optab[3*k +: 3], (i >= 6 && i < 12) ? 8'h00 : injtab[8*k +: 8]);
         if (op_code == 3'd3)
         begin
            last_a = op_addr;
            last_d = op_data;
            do_op(3'd0, 8'h00);
            do_rd(last_a);
            do_rd(last_a ^ 21'h00_0001);
         end
         $display("test %0d done", i);
      end
      do_op(3'd3, 8'h00);
      do_op(3'd4, 8'h00);
      check({15'h0000, prog_suspended}, 16'h0000);
      do_op(3'd5, 8'h00);
      $display("suspend test done");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check({14'h0000, op_ready, flash_ce_n}, 16'h0001);
      rst_n <= 1'b1;
      do_op(3'd3, 8'h10);
      $display("reset test done");
      summarize;
   end
endmodule
